// ### logic/rx_elastic_regs.svh
// Register offsets, field positions, reset values and codes of the
// receive elastic buffer. Assumes a 32-bit APB slave with 8-bit addresses.
`ifndef RX_ELASTIC_REGS_SVH
`define RX_ELASTIC_REGS_SVH

// ****************************************************************
// Buffer geometry
// ****************************************************************
`define BUF_DEPTH        32
`define PTR_W            6
`define ADDR_W           5

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_CONTROL      8'h00
`define OFS_LATENCY      8'h04
`define OFS_SEQ1_LO      8'h08
`define OFS_SEQ1_HI      8'h0C
`define OFS_SEQ2_LO      8'h10
`define OFS_SEQ2_HI      8'h14
`define OFS_MASKS        8'h18
`define OFS_STATUS       8'h1C
`define OFS_COUNTS       8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_BUF_USE     0
`define CTRL_SRC_SEL     1
`define CTRL_CORR_USE    2
`define CTRL_SEQ2_USE    3
`define CTRL_KEEP        4
`define CTRL_PRIO        5
`define CTRL_MATCH_SRC   6
`define CTRL_DISP_USE    7
`define CTRL_INT_WIDTH   8
`define CTRL_LEN_LSB     9
`define CTRL_WORD_LSB    12
`define CTRL_ARST_LSB    15
`define CTRL_SOFT_RST    19
`define LAT_MIN_LSB      0
`define LAT_MAX_LSB      8
`define LAT_WAIT_LSB     16
`define SUB_HI_LSB       16
`define MASK2_LSB        4

// ****************************************************************
// Reset values and writable-bit masks
// ****************************************************************
`define CTRL_RESET       32'h00001203
`define CTRL_MASK        32'h0007FFFF
`define LAT_RESET        32'h00001808
`define LAT_MASK         32'h001F3F3F
`define SEQ_LO_RESET     32'h00000100
`define SEQ_HI_RESET     32'h00000000
`define SEQ_MASK         32'h03FF03FF
`define MASKS_RESET      32'h000000FF
`define MASKS_MASK       32'h000000FF

// ****************************************************************
// Status and correction count codes
// ****************************************************************
`define STAT_NOMINAL     3'h0
`define STAT_LOW         3'h1
`define STAT_HIGH        3'h2
`define STAT_UNDER       3'h5
`define STAT_OVER        3'h6
`define CNT_NONE         2'h0
`define CNT_SKIP_ONE     2'h1
`define CNT_SKIP_TWO     2'h2
`define CNT_ADD_ONE      2'h3

`endif

// ### logic/rx_elastic_pkg.sv
// Types shared by the receive elastic buffer and its sequence matcher.
// Assumes nothing beyond a SystemVerilog compiler.
package rx_elastic_pkg;

  // Buffer entry symbol: raw[19:10], disparity error[9], k flag[8], data
  typedef logic [19:0] entry_sym_t;

  // Correction subsequence value
  typedef logic [9:0] sub_t;

  // Read side progress
  typedef enum logic [1:0] {FILL, STREAM, REPEAT} read_state_e;

endpackage

// ### logic/seq_matcher.sv
// Correction sequence matcher over a window of four buffered symbols.
// Assumes window[0] is the oldest symbol and faces subsequence one.
`timescale 1ns/100ps

module seq_matcher (
  input  wire rx_elastic_pkg::entry_sym_t [3:0] window,
  input  wire rx_elastic_pkg::sub_t       [3:0] seq_one,
  input  wire rx_elastic_pkg::sub_t       [3:0] seq_two,
  input  wire logic                       [3:0] seq_one_mask,
  input  wire logic                       [3:0] seq_two_mask,
  input  wire logic                             seq_two_use,
  input  wire logic                       [2:0] sequence_length,
  input  wire logic                             decoded_sel,
  input  wire logic                             eight_bit_path,
  input  wire logic                             disparity_match_use,
  output wire logic                             match
);

  // Compare one symbol against one subsequence under the active bit care
  function automatic logic sym_match(
    input rx_elastic_pkg::entry_sym_t sym,
    input rx_elastic_pkg::sub_t       sub,
    input logic                       dec,
    input logic                       eight,
    input logic                       disp
  );
    rx_elastic_pkg::sub_t val;
    rx_elastic_pkg::sub_t care;
    val  = dec ? sym[9:0] : sym[19:10];
    care = 10'h3FF;
    if (eight) care = 10'h0FF;
    else if (dec && !disp) care = 10'h1FF;
    sym_match = ((val ^ sub) & care) == 10'h000;
  endfunction

  logic [3:0] hit_one;
  logic [3:0] hit_two;

  // Positions beyond the length or with a clear mask bit match freely
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pos
      wire in_len = (3'(i) < sequence_length);
      assign hit_one[i] = !in_len || !seq_one_mask[i] ||
                          sym_match(window[i], seq_one[i], decoded_sel,
                                    eight_bit_path, disparity_match_use);
      assign hit_two[i] = !in_len || !seq_two_mask[i] ||
                          sym_match(window[i], seq_two[i], decoded_sel,
                                    eight_bit_path, disparity_match_use);
    end
  endgenerate

  // First sequence always searched, second only when in use
  assign match = (&hit_one) || (seq_two_use && (&hit_two));

endmodule // seq_matcher

// ### logic/rx_elastic_buffer.sv
// Receive elastic buffer with clock correction and an APB register file.
// Assumes link and user clocks are slow pins sampled by clock; link data
// changes on the rising edge of line_parallel_clock.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "rx_elastic_regs.svh"

// Summary of operation
// - After overflow or underflow contents are invalid until a buffer reset.
// - Bonding change, realign, idle or rate change may reset, per enable.
// - Minimum latency sets buffer fill latency even without correction.
// - Remove sequences when too full, replicate when too empty.
// - Status codes: 000 nominal, 001 low, 010 high, 101 under, 110 over.
// - Count shown with first sequence byte: 00 none, 01/10 skipped, 11 added.
// - Match source is decoded data only while the decoder is enabled.
// - Keep-one option leaves a sequence in every continuous run.
// - Occupancy above maximum removes incoming correction sequences.
// - Occupancy below minimum replicates incoming correction sequences.
// - Priority option settles correction versus bonding in the same cycle.
// - Programmable minimum user cycles between corrections, 0 means free.
// - Sequence length 1, 2 or 4 sets match size and adjust size.
// - Four subsequences per sequence, mask bit set means compared.
// - First sequence always matched, second only when enabled.
// - Disparity match option compares or ignores disparity error status.
// - Comma word setting must agree with length and internal width.
// - Narrow byte paths compare only the lower eight bits.
module rx_elastic_buffer (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_parallel_clock,
  input  wire logic [9:0]  link_raw_in,
  input  wire logic [7:0]  link_data_in,
  input  wire logic        link_k_in,
  input  wire logic        link_disp_err_in,
  input  wire logic        user_receive_clock,
  input  wire logic        buffer_reset_in,
  input  wire logic        transceiver_receive_reset,
  input  wire logic        receive_pcs_reset,
  input  wire logic        decoder_enable_in,
  input  wire logic        bond_change_in,
  input  wire logic        comma_realign_in,
  input  wire logic        elec_idle_in,
  input  wire logic        rate_change_in,
  input  wire logic        bonding_trigger_in,
  output logic      [9:0]  receive_data_out,
  output logic             data_valid_out,
  output logic      [2:0]  buffer_status_out,
  output logic      [1:0]  correction_count_out,
  output logic             bonding_accept_out
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int SW = 31;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic          link_clk_d;
  logic          user_clk_d;

  // Two flops on every pin except clock, reset and the APB pins before any logic looks at it
  always_ff @(posedge clock) begin
    pin_meta <= {line_parallel_clock, user_receive_clock, buffer_reset_in,
                 transceiver_receive_reset, receive_pcs_reset,
                 decoder_enable_in, bond_change_in, comma_realign_in,
                 elec_idle_in, rate_change_in, bonding_trigger_in,
                 link_raw_in, link_disp_err_in, link_k_in, link_data_in};
    pin_sync <= pin_meta;
    link_clk_d <= pin_sync[30];
    user_clk_d <= pin_sync[29];
  end

  wire                         link_clk_s = pin_sync[30];
  wire                         user_clk_s = pin_sync[29];
  wire [2:0]                   ext_resets = pin_sync[28:26];
  wire                         dec_en     = pin_sync[25];
  wire [3:0]                   auto_evt   = pin_sync[24:21];
  wire                         bond_req   = pin_sync[20];
  wire rx_elastic_pkg::entry_sym_t link_sym = pin_sync[19:0];
  // Write on link falling edge, where the data is settled
  wire wr_edge = link_clk_d && !link_clk_s;
  wire rd_edge = user_clk_s && !user_clk_d;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [31:0] ctrl;
  logic [31:0] lat;
  logic [31:0] seq1_lo;
  logic [31:0] seq1_hi;
  logic [31:0] seq2_lo;
  logic [31:0] seq2_hi;
  logic [31:0] masks;
  logic [15:0] skip_total;
  logic [15:0] add_total;
  logic        soft_reset;
  logic [2:0]  next_status;
  logic [`PTR_W-1:0] occ;
  logic        cfg_err;

  // Map a byte address to a register index, 15 for unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    case (a)
      `OFS_CONTROL: reg_index = 4'h0;
      `OFS_LATENCY: reg_index = 4'h1;
      `OFS_SEQ1_LO: reg_index = 4'h2;
      `OFS_SEQ1_HI: reg_index = 4'h3;
      `OFS_SEQ2_LO: reg_index = 4'h4;
      `OFS_SEQ2_HI: reg_index = 4'h5;
      `OFS_MASKS:   reg_index = 4'h6;
      `OFS_STATUS:  reg_index = 4'h7;
      `OFS_COUNTS:  reg_index = 4'h8;
      default:      reg_index = 4'hF;
    endcase
  endfunction

  wire [3:0]  ridx      = reg_index(paddr);
  wire        setup     = psel && !penable;
  wire        wr_access = psel && penable && pwrite && pready;
  wire [3:0]  widx      = wr_access ? ridx : 4'hF;
  wire [31:0] rd_mux    =
      (ridx == 4'h0) ? ctrl :
      (ridx == 4'h1) ? lat :
      (ridx == 4'h2) ? seq1_lo :
      (ridx == 4'h3) ? seq1_hi :
      (ridx == 4'h4) ? seq2_lo :
      (ridx == 4'h5) ? seq2_hi :
      (ridx == 4'h6) ? masks :
      (ridx == 4'h7) ? {22'h0, cfg_err, occ, next_status} :
      (ridx == 4'h8) ? {add_total, skip_total} : 32'h0;

  // Answer prepared in setup, write applied at the access edge
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && (ridx == 4'hF);
      if (setup) prdata <= rd_mux;
    end
  end

  // Configuration words, reserved bits held at zero
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= `CTRL_RESET;
      lat <= `LAT_RESET;
      seq1_lo <= `SEQ_LO_RESET;
      seq1_hi <= `SEQ_HI_RESET;
      seq2_lo <= `SEQ_LO_RESET;
      seq2_hi <= `SEQ_HI_RESET;
      masks <= `MASKS_RESET;
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= (widx == 4'h0) && pwdata[`CTRL_SOFT_RST];
      if (widx == 4'h0) ctrl <= pwdata & `CTRL_MASK & ~32'h00080000;
      if (widx == 4'h1) lat <= pwdata & `LAT_MASK;
      if (widx == 4'h2) seq1_lo <= pwdata & `SEQ_MASK;
      if (widx == 4'h3) seq1_hi <= pwdata & `SEQ_MASK;
      if (widx == 4'h4) seq2_lo <= pwdata & `SEQ_MASK;
      if (widx == 4'h5) seq2_hi <= pwdata & `SEQ_MASK;
      if (widx == 4'h6) masks <= pwdata & `MASKS_MASK;
    end
  end

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  wire       buf_use   = ctrl[`CTRL_BUF_USE] && ctrl[`CTRL_SRC_SEL];
  wire       corr_use  = ctrl[`CTRL_CORR_USE];
  wire       keep_one  = ctrl[`CTRL_KEEP];
  wire       prio      = ctrl[`CTRL_PRIO];
  wire [2:0] seq_len   = ctrl[`CTRL_LEN_LSB +: 3];
  wire [2:0] word      = ctrl[`CTRL_WORD_LSB +: 3];
  wire [3:0] arst_en   = ctrl[`CTRL_ARST_LSB +: 4];
  wire [5:0] min_lat   = lat[`LAT_MIN_LSB +: 6];
  wire [5:0] max_lat   = lat[`LAT_MAX_LSB +: 6];
  wire [4:0] spacing   = lat[`LAT_WAIT_LSB +: 5];
  wire       len_ok    = (seq_len == 3'd1) || (seq_len == 3'd2) ||
                         (seq_len == 3'd4);
  wire       word_ok   = (word == 3'd1) ||
                         (word == 3'd2 && seq_len != 3'd1) ||
                         (word == 3'd4 && seq_len == 3'd4 &&
                          ctrl[`CTRL_INT_WIDTH]);
  assign cfg_err = !len_ok || !word_ok;
  wire [5:0] len6      = {3'b000, seq_len};

  // Any reset source empties the buffer and restarts the fill
  wire flush = reset || soft_reset || (|ext_resets) || !buf_use ||
               (|(auto_evt & arst_en));

  // ****************************************************************
  // Write side: lookahead window and storage
  // ****************************************************************
  rx_elastic_pkg::entry_sym_t [3:0] win;
  logic [3:0]                win_valid;
  logic [20:0]               mem [0:`BUF_DEPTH-1];
  logic [`PTR_W-1:0]         wr_ptr;
  logic [`PTR_W-1:0]         rd_ptr;
  logic                      overflow;
  logic                      seq_hit;

  assign occ = wr_ptr - rd_ptr;
  wire              full = (occ == 6'(`BUF_DEPTH));

  seq_matcher u_match (
    .window              (win),
    .seq_one             ({seq1_hi[`SUB_HI_LSB +: 10], seq1_hi[9:0],
                           seq1_lo[`SUB_HI_LSB +: 10], seq1_lo[9:0]}),
    .seq_two             ({seq2_hi[`SUB_HI_LSB +: 10], seq2_hi[9:0],
                           seq2_lo[`SUB_HI_LSB +: 10], seq2_lo[9:0]}),
    .seq_one_mask        (masks[3:0]),
    .seq_two_mask        (masks[`MASK2_LSB +: 4]),
    .seq_two_use         (ctrl[`CTRL_SEQ2_USE]),
    .sequence_length     (seq_len),
    .decoded_sel         (ctrl[`CTRL_MATCH_SRC] && dec_en),
    .eight_bit_path      (!dec_en),
    .disparity_match_use (ctrl[`CTRL_DISP_USE]),
    .match               (seq_hit)
  );

  // Oldest window symbol enters the buffer, tagged when a sequence starts
  always_ff @(posedge clock) begin
    if (flush) begin
      win_valid <= 4'h0;
      wr_ptr    <= '0;
      overflow  <= 1'b0;
    end else if (wr_edge) begin
      win       <= {link_sym, win[3:1]};
      win_valid <= {1'b1, win_valid[3:1]};
      if (win_valid[0] && full) overflow <= 1'b1;
      if (win_valid[0] && !full) wr_ptr <= wr_ptr + 6'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_edge && win_valid[0] && !full)
      mem[wr_ptr[`ADDR_W-1:0]] <= {seq_hit, win[0]};
  end

  // ****************************************************************
  // Read side: correction decisions
  // ****************************************************************
  rx_elastic_pkg::read_state_e state;
  logic [`PTR_W-1:0] rep_base;
  logic [2:0]        rep_left;
  logic [2:0]        guard;
  logic [4:0]        gap;
  logic              underflow;

  wire [20:0] ent0 = mem[rd_ptr[`ADDR_W-1:0]];
  wire [20:0] ent1 = mem[5'(rd_ptr + len6)];
  wire [20:0] ent2 = mem[5'(rd_ptr + len6 + len6)];
  wire too_high = occ > max_lat;
  wire too_low  = occ < min_lat;
  wire gap_ok   = (spacing == 5'd0) || (gap >= spacing);
  wire corr_on  = corr_use && !cfg_err && (state == rx_elastic_pkg::STREAM)
                  && (guard == 3'd0) && gap_ok && ent0[20];
  wire corr_opp = corr_on && (too_high || too_low);
  wire corr_go  = corr_opp && (prio || !bond_req);
  wire skip_one = corr_go && too_high && (occ > len6) &&
                  (!keep_one || ent1[20]);
  wire skip_two = skip_one && ent1[20] && (occ > len6 + len6) &&
                  ((occ - len6) > max_lat) && (!keep_one || ent2[20]);
  wire rep_go   = corr_go && too_low;
  wire [20:0] shown = skip_two ? ent2 : (skip_one ? ent1 : ent0);
  wire [`PTR_W-1:0] step = skip_two ? len6 + len6 + 6'd1 :
                           (skip_one ? len6 + 6'd1 : 6'd1);
  wire [1:0] next_count = skip_two ? `CNT_SKIP_TWO :
                          skip_one ? `CNT_SKIP_ONE :
                          rep_go   ? `CNT_ADD_ONE : `CNT_NONE;
  wire [9:0] next_data = dec_en ? shown[9:0] : shown[19:10];
  wire       empty     = (occ == 6'd0);

  // Fill to minimum latency, then stream, replaying on a repeat
  always_ff @(posedge clock) begin
    if (flush) begin
      state <= rx_elastic_pkg::FILL;
      rd_ptr <= '0;
      rep_base <= '0;
      rep_left <= 3'd0;
      guard <= 3'd0;
      underflow <= 1'b0;
    end else if (rd_edge) begin
      case (state)
        rx_elastic_pkg::FILL: begin
          if (!empty && !too_low) state <= rx_elastic_pkg::STREAM;
        end
        rx_elastic_pkg::STREAM: begin
          if (empty) underflow <= 1'b1;
          else if (rep_go && seq_len != 3'd1) begin
            state <= rx_elastic_pkg::REPEAT;
            rep_base <= rd_ptr;
            rep_left <= seq_len - 3'd1;
            rd_ptr <= rd_ptr + 6'd1;
          end else if (rep_go) guard <= seq_len;
          else begin
            rd_ptr <= rd_ptr + step;
            if (skip_one) guard <= seq_len - 3'd1;
            else if (guard != 3'd0) guard <= guard - 3'd1;
          end
        end
        rx_elastic_pkg::REPEAT: begin
          if (rep_left == 3'd1) begin
            rd_ptr <= rep_base;
            guard <= seq_len;
            state <= rx_elastic_pkg::STREAM;
          end else begin
            rd_ptr <= rd_ptr + 6'd1;
            rep_left <= rep_left - 3'd1;
          end
        end
        default: state <= rx_elastic_pkg::FILL;
      endcase
    end
  end

  // User cycles since the last correction, saturating
  always_ff @(posedge clock) begin
    if (flush) gap <= 5'd0;
    else if (rd_edge && (skip_one || rep_go)) gap <= 5'd0;
    else if (rd_edge && gap != 5'h1F) gap <= gap + 5'd1;
  end

  // ****************************************************************
  // User side outputs and counters
  // ****************************************************************
  wire streaming = (state != rx_elastic_pkg::FILL) && !empty &&
                   !underflow;

  always_ff @(posedge clock) begin
    if (flush) begin
      receive_data_out <= 10'h0;
      data_valid_out <= 1'b0;
      correction_count_out <= `CNT_NONE;
    end else if (rd_edge) begin
      data_valid_out <= streaming;
      correction_count_out <= streaming ? next_count : `CNT_NONE;
      if (streaming) receive_data_out <= next_data;
    end
  end

  // Status priority: overflow, underflow, nominal while filling, high, low, nominal
  assign next_status = overflow  ? `STAT_OVER :
                       underflow ? `STAT_UNDER :
                       (state == rx_elastic_pkg::FILL) ? `STAT_NOMINAL :
                       too_high  ? `STAT_HIGH :
                       too_low   ? `STAT_LOW : `STAT_NOMINAL;

  always_ff @(posedge clock) begin
    if (reset) begin
      buffer_status_out <= `STAT_NOMINAL;
      bonding_accept_out <= 1'b0;
      skip_total <= 16'h0;
      add_total <= 16'h0;
    end else begin
      buffer_status_out <= next_status;
      bonding_accept_out <= bond_req && !(rd_edge && corr_opp && prio);
      if (rd_edge && skip_one) skip_total <= skip_total + 16'h1;
      if (rd_edge && rep_go) add_total <= add_total + 16'h1;
    end
  end

endmodule // rx_elastic_buffer

// ### sim/rx_elastic_buffer_monitor.sv
// Checker of the buffer ports: APB answers and status outputs.
// Assumes one clock domain; bound to every buffer instance.
`timescale 1ns/100ps
`include "rx_elastic_regs.svh"
module rx_elastic_monitor (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [2:0] buffer_status_out,
  input wire logic [1:0] correction_count_out,
  input wire logic       data_valid_out
);
  // ****
  // Port relations
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // APB setup cycle
  sequence apb_setup;
    psel && !penable;
  endsequence
  a_ready_after_setup: assert property (apb_setup |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_status_code: assert property (buffer_status_out inside
    {`STAT_NOMINAL, `STAT_LOW, `STAT_HIGH, `STAT_UNDER, `STAT_OVER})
    else $error("bad status code");
  a_count_with_data: assert property (
    correction_count_out != `CNT_NONE |-> data_valid_out)
    else $error("count without data");
  a_under_no_data: assert property (
    buffer_status_out == `STAT_UNDER |-> !data_valid_out)
    else $error("data after underflow");
  a_reset_clean: assert property ($fell(reset) |-> !pready &&
    !data_valid_out && buffer_status_out == `STAT_NOMINAL)
    else $error("outputs not clean after reset");
endmodule // rx_elastic_monitor
bind rx_elastic_buffer rx_elastic_monitor u_monitor (.clock, .reset, .psel,
  .penable, .pready, .pslverr, .buffer_status_out, .correction_count_out,
  .data_valid_out);

// ### sim/user_fabric_model.sv
// User fabric model: makes the local user clock that reads the buffer.
// Assumes the bench clock; the rate is set by the bench.
`timescale 1ns/100ps
module user_fabric_model (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [3:0] half,
  output logic            user_receive_clock
);
  logic [3:0] cnt;
  // ****
  // Local user clock
  // ****
  // Halts in place while run is low
  always @(posedge clock) begin
    if (reset) begin
      cnt <= 4'h0;
      user_receive_clock <= 1'b0;
    end else if (run) begin
      cnt <= (cnt >= half - 4'h1) ? 4'h0 : cnt + 4'h1;
      if (cnt >= half - 4'h1) user_receive_clock <= !user_receive_clock;
    end
  end
endmodule // user_fabric_model

// ### sim/tb_rx_elastic_buffer.sv
// Bench of the elastic buffer: APB setup, link traffic, user reads.
// Assumes the checker is bound and the user fabric model is compiled.
`timescale 1ns/100ps
`include "rx_elastic_regs.svh"
module tb_rx_elastic_buffer;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, seqn, lcnt, link_data_in;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  link_raw_in, receive_data_out;
  logic [3:0]  flush, half;
  logic [2:0]  buffer_status_out;
  logic [1:0]  correction_count_out;
  logic        line_parallel_clock, link_k_in, user_receive_clock, lrun;
  logic        urun, decoder_enable_in, data_valid_out, bonding_accept_out;
  int          num_errors, tests_run, n;
  logic [7:0]  addrs [6] = '{`OFS_CONTROL, `OFS_LATENCY, `OFS_SEQ1_LO,
                             `OFS_MASKS, `OFS_STATUS, 8'h40};
  logic [31:0] inits [6] = '{`CTRL_RESET, `LAT_RESET, `SEQ_LO_RESET,
                             `MASKS_RESET, 32'h0, 32'h0};
  // ****
  // Stimulus and partner
  // ****
  // Sequence symbol on every fourth count, data otherwise
  assign link_k_in    = (seqn[1:0] == 2'h0);
  assign link_raw_in  = link_k_in ? 10'h100 : {2'h0, seqn};
  assign link_data_in = link_k_in ? 8'h00 : seqn;
  rx_elastic_buffer uut (.clock, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .line_parallel_clock, .link_raw_in,
    .link_data_in, .link_k_in, .link_disp_err_in(1'b0), .user_receive_clock,
    .buffer_reset_in(flush[0]), .transceiver_receive_reset(flush[1]),
    .receive_pcs_reset(flush[2]), .bond_change_in(flush[3]),
    .decoder_enable_in, .comma_realign_in(1'b0), .elec_idle_in(1'b0),
    .rate_change_in(1'b0), .bonding_trigger_in(flush[3]), .receive_data_out,
    .data_valid_out, .buffer_status_out, .correction_count_out,
    .bonding_accept_out);
  user_fabric_model partner (.clock, .reset, .run(urun), .half,
    .user_receive_clock);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = !clock;
  end
  // Link clock of 200 ns, new symbol at each rising edge, still when idle
  always @(posedge clock) begin
    lcnt <= (lcnt == 8'h03) ? 8'h00 : lcnt + 8'h01;
    if (lcnt == 8'h03 && lrun) begin
      line_parallel_clock <= !line_parallel_clock;
      if (!line_parallel_clock) seqn <= seqn + 8'h01;
    end
  end
  // ****
  // Tasks
  // ****
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for a count (c high) or a status value, then compares it
  task wait_out(input logic c, input logic [2:0] v);
    n = 0;
    while ((c ? correction_count_out : buffer_status_out) !== v && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    check(c ? correction_count_out : buffer_status_out, v);
  endtask
  task pulse(input int i);
    flush[i] <= 1'b1;
    repeat (8) @(posedge clock);
    if (i == 3) check(bonding_accept_out, 1'b1);
    flush[i] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    {psel, penable, pwrite, paddr, pwdata, lrun, urun, flush} = '0;
    {lcnt, seqn, line_parallel_clock, num_errors, tests_run} = '0;
    half = 4'h4;
    decoder_enable_in = 1'b1;
    reset = 1'b1;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, addrs[i], 32'h0);
      check(rd, inits[i]);
      check(err, i == 5);
    end
    apb(1'b1, `OFS_CONTROL, 32'h000C1207);
    apb(1'b0, `OFS_CONTROL, 32'h0);
    check(rd, 32'h00041207);
    $display("registers done");
    lrun <= 1'b1;
    urun <= 1'b1;
    n = 0;
    while (data_valid_out !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    check(receive_data_out, 10'h001);
    wait_out(1'b0, `STAT_NOMINAL);
    half <= 4'h5;
    wait_out(1'b0, `STAT_HIGH);
    wait_out(1'b1, `CNT_SKIP_ONE);
    half <= 4'h3;
    wait_out(1'b0, `STAT_LOW);
    wait_out(1'b1, `CNT_ADD_ONE);
    $display("correction done");
    urun <= 1'b0;
    wait_out(1'b0, `STAT_OVER);
    pulse(0);
    check(buffer_status_out, `STAT_NOMINAL);
    urun <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      lrun <= 1'b1;
      repeat (400) @(posedge clock);
      lrun <= 1'b0;
      wait_out(1'b0, `STAT_UNDER);
      pulse(i);
      check(buffer_status_out, `STAT_NOMINAL);
      check(data_valid_out, 1'b0);
    end
    $display("flush done");
    results();
  end
  // Watchdog over the whole run
  initial begin
    #1500000;
    num_errors++;
    results();
  end
endmodule // tb_rx_elastic_buffer
